/* File: irr_cfg.svh */
// Purpose: offsets, reset values, interrupt lines and codes for the routing registers
// Assumes: indexed access through an index/data port pair
// Notes:   definitions only
`ifndef IRR_CFG_SVH
`define IRR_CFG_SVH

// index numbers within the configuration index space
`define IRR_IDX_ROUTE_E      8'hD8
`define IRR_IDX_LOW_UPPER    8'hD9
`define IRR_IDX_HIGH_UPPER   8'hDA
`define IRR_IDX_ROUTE_A      8'hDB
`define IRR_IDX_ROUTE_B      8'hDC

// cursor address high/low registers in the display index space
`define IRR_CURSOR_HI_IDX    8'h0E
`define IRR_CURSOR_LO_IDX    8'h0F

// reset values
`define IRR_RST_REG          8'h00
`define IRR_RST_INDEX        8'h00

// interrupt controller inputs driven by this block
`define IRR_IRQ_SERIAL_A     3
`define IRR_IRQ_SERIAL_B     4
`define IRR_IRQ_PAR_A        5
`define IRR_IRQ_PAR_B        7
`define IRR_IRQ_CURSOR       9

// two-bit route codes
`define IRR_CODE2_OFF        2'h0
`define IRR_CODE2_FIRST      2'h1
`define IRR_CODE2_SECOND     2'h2
`define IRR_CODE2_THIRD      2'h3

// number of DMA request sources routed
`define IRR_DMA_SRCS         5

`endif

/* File: irr_dma_ctrl_model.sv */
// Purpose: behavioural DMA controller facing the routing block
// Assumes: grants the lowest numbered requesting channel
// Notes:   slow adds one cycle before each acknowledge
`timescale 1ns/1ps

module irr_dma_ctrl_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic [7:0] chanDrq,
  output logic      [7:0] dmaAck
);
  logic [7:0] pend_q;
  logic [7:0] win;

  // lowest request wins; ack drops once the request goes away
  always_comb begin
    win = slow ? (pend_q & chanDrq) : chanDrq;
    win = win & (~win + 8'h01);
  end

  // registered grant and delayed request copy
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_q <= 8'h00;
      dmaAck <= 8'h00;
    end else begin
      pend_q <= chanDrq;
      dmaAck <= win;
    end
  end
endmodule

/* File: irr_dma_xbar.sv */
// Purpose: joins routed DMA sources onto the eight internal channels
// Assumes: each source carries a one-hot (or zero) channel mask
// Notes:   purely combinational, the parent registers the results
`timescale 1ns/1ps
`include "irr_cfg.svh"

module irr_dma_xbar
  import irr_pkg::*;
(
  input  wire logic [`IRR_DMA_SRCS-1:0][7:0] srcMask,
  input  wire logic [`IRR_DMA_SRCS-1:0]      srcReq,
  input  wire logic [7:0]                    chanAck,
  output logic      [7:0]                    chanReq,
  output logic      [`IRR_DMA_SRCS-1:0]      srcAck
);

  // requests OR onto a shared channel, each requesting source sees its channel acknowledge
  always_comb begin
    chanReq = 8'h00;
    for (int s = 0; s < `IRR_DMA_SRCS; s++) begin
      chanReq = chanReq | (srcMask[s] & {8{srcReq[s]}});
    end
  end

  // acknowledge back only to a requesting source, so shared channels do not
  // hand one source a cycle that another asked for
  genvar g;
  generate
    for (g = 0; g < `IRR_DMA_SRCS; g++) begin : gAck
      assign srcAck[g] = srcReq[g] & (|(srcMask[g] & chanAck));
    end
  endgenerate

endmodule

/* File: irr_pkg.sv */
// Purpose: shared types of the routing register block
// Assumes: nothing
// Notes:   field order is msb first
package irr_pkg;

  // interrupt route register E
  typedef struct packed {
    logic       cursorWriteIrqEnable;
    logic [1:0] serialIrRoute;
    logic [1:0] parallelIrqRoute;
    logic [2:0] spare;
  } irr_route_e_t;

  // DMA channel map register A
  typedef struct packed {
    logic [1:0] infraredDmaRoute;
    logic [2:0] pinPair1DmaRoute;
    logic [2:0] pinPair0DmaRoute;
  } irr_map_a_t;

  // DMA channel map register B
  typedef struct packed {
    logic [3:0] spare;
    logic [1:0] cardBDmaRoute;
    logic [1:0] cardADmaRoute;
  } irr_map_b_t;

  // one port access of the index/data pair
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       dataPort;
    logic [7:0] wrData;
  } irr_io_t;

endpackage

/* File: irr_route_regs.sv */
// Purpose: indexed registers routing interrupts and DMA pairs, plus upper address bits
// Assumes: sys_clk 50 MHz, all inputs synchronous, rst synchronous active high
// Notes:   index port and data port are selected by ioDataPort
// Behaviour
// - cursor writes raise line 9 when enabled
// - serial route code 01/10 picks input 3/4
// - serial or slow infrared uses serial causes
// - high speed infrared uses infrared causes only
// - channels 0-3 upper address bits, reset zero
// - channels 5-7 upper address bits, reset zero
// - infrared DMA route 01/10 picks channel 0/1
// - pin pair codes pick channels 0-3, 5-7
// - card A codes pick channel 3, 2, 5
`timescale 1ns/1ps
`include "irr_cfg.svh"

module irr_route_regs
  import irr_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic                       ioWr,
  input  wire logic                       ioRd,
  input  wire logic                       ioDataPort,
  input  wire logic [7:0]                 ioWrData,
  output logic      [7:0]                 ioRdData,
  input  wire logic                       cursorRegWr,
  input  wire logic [7:0]                 cursorRegIdx,
  input  wire logic                       uartIrq,
  input  wire logic                       irdaIrq,
  input  wire logic                       infraredSelect,
  input  wire logic                       highSpeedSelect,
  input  wire logic                       parallelPortIrq,
  output logic      [15:0]                irqOut,
  input  wire logic                       irdaDrq,
  input  wire logic [1:0]                 pinDmaRequest,
  input  wire logic [1:0]                 cardDrq,
  input  wire logic [7:0]                 dmaAck,
  output logic      [7:0]                 chanDrq,
  output logic                            irdaDack,
  output logic      [1:0]                 pinDmaAck,
  output logic      [1:0]                 cardDack,
  output logic      [7:0]                 lowChanUpperAddr,
  output logic      [7:0]                 highChanUpperAddr
);

  ////////////////////////////////////////////////////////////////////////////
  // decode functions

  // two-bit code to a one-hot channel mask with three given targets
  function automatic logic [7:0] irrDecode2(input logic [1:0] code,
                                            input logic [7:0] m1,
                                            input logic [7:0] m2,
                                            input logic [7:0] m3);
    case (code)
      `IRR_CODE2_FIRST:  irrDecode2 = m1;
      `IRR_CODE2_SECOND: irrDecode2 = m2;
      `IRR_CODE2_THIRD:  irrDecode2 = m3;
      default:           irrDecode2 = 8'h00;
    endcase
  endfunction

  // three-bit pin code: 000 off, 001-100 channels 0-3, 101-111 channels 5-7
  function automatic logic [7:0] irrDecodePin(input logic [2:0] code);
    irrDecodePin = (code == 3'h0) ? 8'h00 :
                   (code <= 3'h4) ? (8'h01 << (code - 3'h1)) : (8'h01 << code);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register state

  irr_io_t      io;
  logic [7:0]   index_q, index_d;
  irr_route_e_t routeE_q, routeE_d;
  irr_map_a_t   mapA_q, mapA_d;
  irr_map_b_t   mapB_q, mapB_d;
  logic [7:0]   lowUp_q, lowUp_d;
  logic [7:0]   highUp_q, highUp_d;
  logic [7:0]   rdData_q, rdData_d;
  logic         dataWr;

  assign io = '{wr: ioWr, rd: ioRd, dataPort: ioDataPort, wrData: ioWrData};
  assign dataWr = io.wr & io.dataPort;

  // next register values from index/data port writes
  always_comb begin
    index_d  = index_q;
    routeE_d = routeE_q;
    mapA_d   = mapA_q;
    mapB_d   = mapB_q;
    lowUp_d  = lowUp_q;
    highUp_d = highUp_q;
    rdData_d = rdData_q;
    if (io.wr && !io.dataPort) begin
      index_d = io.wrData;
    end
    if (dataWr) begin
      case (index_q)
        `IRR_IDX_ROUTE_E:    routeE_d = io.wrData;
        `IRR_IDX_LOW_UPPER:  lowUp_d  = io.wrData;
        `IRR_IDX_HIGH_UPPER: highUp_d = io.wrData;
        `IRR_IDX_ROUTE_A:    mapA_d   = io.wrData;
        `IRR_IDX_ROUTE_B:    mapB_d   = io.wrData;
        default: ;
      endcase
    end
    if (io.rd) begin
      if (!io.dataPort) begin
        rdData_d = index_q;
      end else begin
        case (index_q)
          `IRR_IDX_ROUTE_E:    rdData_d = routeE_q;
          `IRR_IDX_LOW_UPPER:  rdData_d = lowUp_q;
          `IRR_IDX_HIGH_UPPER: rdData_d = highUp_q;
          `IRR_IDX_ROUTE_A:    rdData_d = mapA_q;
          `IRR_IDX_ROUTE_B:    rdData_d = mapB_q;
          default:             rdData_d = 8'h00;
        endcase
      end
    end
  end

  // register stage, frozen while ce is low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      index_q  <= `IRR_RST_INDEX;
      routeE_q <= `IRR_RST_REG;
      mapA_q   <= `IRR_RST_REG;
      mapB_q   <= `IRR_RST_REG;
      lowUp_q  <= `IRR_RST_REG;
      highUp_q <= `IRR_RST_REG;
      rdData_q <= `IRR_RST_REG;
    end else if (ce) begin
      index_q  <= index_d;
      routeE_q <= routeE_d;
      mapA_q   <= mapA_d;
      mapB_q   <= mapB_d;
      lowUp_q  <= lowUp_d;
      highUp_q <= highUp_d;
      rdData_q <= rdData_d;
    end
  end

  assign ioRdData          = rdData_q;
  assign lowChanUpperAddr  = lowUp_q;
  assign highChanUpperAddr = highUp_q;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt routing

  logic [15:0] irq_q, irq_d;
  logic        serialSrc;
  logic        cursorHit;

  // serial causes unless high speed infrared
  // infrared causes in high speed mode
  assign serialSrc = (infraredSelect && highSpeedSelect) ? irdaIrq : uartIrq;
  assign cursorHit = cursorRegWr && (cursorRegIdx == `IRR_CURSOR_HI_IDX ||
                                     cursorRegIdx == `IRR_CURSOR_LO_IDX);

  always_comb begin
    irq_d = 16'h0000;
    if (routeE_q.serialIrRoute == `IRR_CODE2_FIRST)
      irq_d[`IRR_IRQ_SERIAL_A] = serialSrc;
    if (routeE_q.serialIrRoute == `IRR_CODE2_SECOND)
      irq_d[`IRR_IRQ_SERIAL_B] = serialSrc;
    if (routeE_q.parallelIrqRoute == `IRR_CODE2_FIRST)
      irq_d[`IRR_IRQ_PAR_A] = parallelPortIrq;
    if (routeE_q.parallelIrqRoute == `IRR_CODE2_SECOND)
      irq_d[`IRR_IRQ_PAR_B] = parallelPortIrq;
    irq_d[`IRR_IRQ_CURSOR] = routeE_q.cursorWriteIrqEnable & cursorHit;
  end

  // interrupt output register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_q <= 16'h0000;
    end else if (ce) begin
      irq_q <= irq_d;
    end
  end

  assign irqOut = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // DMA routing

  logic [`IRR_DMA_SRCS-1:0][7:0] srcMask;
  logic [`IRR_DMA_SRCS-1:0]      srcReq;
  logic [`IRR_DMA_SRCS-1:0]      srcAck;
  logic [7:0]                    chanReq;
  logic [7:0]                    chanDrq_q;
  logic [`IRR_DMA_SRCS-1:0]      srcAck_q;

  // infrared to channel 0 or 1
  // pin pairs to byte or word channels
  // card A to channel 3, 2 or 5
  always_comb begin
    srcMask[0] = irrDecode2(mapA_q.infraredDmaRoute, 8'h01, 8'h02, 8'h00);
    srcMask[1] = irrDecodePin(mapA_q.pinPair0DmaRoute);
    srcMask[2] = irrDecodePin(mapA_q.pinPair1DmaRoute);
    srcMask[3] = irrDecode2(mapB_q.cardADmaRoute, 8'h08, 8'h04, 8'h20);
    srcMask[4] = irrDecode2(mapB_q.cardBDmaRoute, 8'h08, 8'h04, 8'h20);
  end

  assign srcReq = {cardDrq[1], cardDrq[0], pinDmaRequest[1], pinDmaRequest[0], irdaDrq};

  irr_dma_xbar irr_dma_xbar_inst (
    .srcMask (srcMask),
    .srcReq  (srcReq),
    .chanAck (dmaAck),
    .chanReq (chanReq),
    .srcAck  (srcAck)
  );

  // DMA output register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chanDrq_q <= 8'h00;
      srcAck_q  <= '0;
    end else if (ce) begin
      chanDrq_q <= chanReq;
      srcAck_q  <= srcAck;
    end
  end

  assign chanDrq   = chanDrq_q;
  assign irdaDack  = srcAck_q[0];
  assign pinDmaAck = srcAck_q[2:1];
  assign cardDack  = srcAck_q[4:3];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_cursor_irq_fire: assert property (
    ce && routeE_q.cursorWriteIrqEnable && cursorHit |=> irqOut[9])
    else $error("cursor write did not raise line 9");
  a_cursor_irq_quiet: assert property (
    ce && !(routeE_q.cursorWriteIrqEnable && cursorHit) |=> !irqOut[9])
    else $error("line 9 raised without enabled cursor write");
  a_serial_line_three: assert property (
    ce && routeE_q.serialIrRoute == 2'h1 && serialSrc |=> irqOut[3] && !irqOut[4])
    else $error("serial interrupt not on line 3");
  a_serial_hs_mask: assert property (
    ce && infraredSelect && highSpeedSelect && !irdaIrq |=> !irqOut[3] && !irqOut[4])
    else $error("serial line driven in high speed mode without infrared cause");
  a_serial_uart_src: assert property (
    ce && !infraredSelect && routeE_q.serialIrRoute == 2'h2 && uartIrq |=> irqOut[4])
    else $error("serial cause not on line 4");
  a_par_line_seven: assert property (
    ce && routeE_q.parallelIrqRoute == 2'h2 |=> irqOut[7] == $past(parallelPortIrq) && !irqOut[5])
    else $error("parallel interrupt not on line 7");
  a_upper_reg_write: assert property (
    ce && dataWr && index_q == 8'hD9 |=> lowChanUpperAddr == $past(ioWrData))
    else $error("low channel upper bits not written");
  a_infrared_chan_one: assert property (
    ce && mapA_q.infraredDmaRoute == 2'h2 && irdaDrq |=> chanDrq[1])
    else $error("infrared request missing on channel 1");
  a_card_a_word: assert property (
    ce && mapB_q.cardADmaRoute == 2'h3 && cardDrq[0] |=> chanDrq[5])
    else $error("card A request missing on channel 5");
  a_pin_ack_pair: assert property (
    ce && mapA_q.pinPair0DmaRoute == 3'h5 && pinDmaRequest[0] && dmaAck[5] |=> pinDmaAck[0])
    else $error("pin pair 0 acknowledge missing from channel 5");

  c_cursor_irq: cover property (ce && routeE_q.cursorWriteIrqEnable && cursorHit);
  c_hs_infrared: cover property (ce && infraredSelect && highSpeedSelect && irdaIrq);
  c_shared_chan: cover property (ce && srcReq[0] && srcReq[1] && |(srcMask[0] & srcMask[1]));

endmodule

/* File: irr_route_regs_tb.sv */
// Purpose: self-checking bench for the routing register block
// Assumes: index/data port access, 50 MHz clock
// Notes:   DMA acknowledges come from the controller model
`timescale 1ns/1ps
`include "irr_cfg.svh"

module irr_route_regs_tb;
  logic        sys_clk, rst, ce, ioWr, ioRd, ioDataPort, cursorRegWr, slow;
  logic        uartIrq, irdaIrq, infraredSelect, highSpeedSelect, parallelPortIrq;
  logic        irdaDrq, irdaDack;
  logic [1:0]  pinDmaRequest, cardDrq, pinDmaAck, cardDack;
  logic [7:0]  ioWrData, ioRdData, cursorRegIdx, dmaAck, chanDrq;
  logic [7:0]  lowChanUpperAddr, highChanUpperAddr;
  logic [15:0] irqOut;
  int          n_errors, checks_done;

  irr_route_regs irr_route_regs_inst (
    .sys_clk, .rst, .ce, .ioWr, .ioRd, .ioDataPort, .ioWrData, .ioRdData,
    .cursorRegWr, .cursorRegIdx, .uartIrq, .irdaIrq, .infraredSelect,
    .highSpeedSelect, .parallelPortIrq, .irqOut, .irdaDrq, .pinDmaRequest,
    .cardDrq, .dmaAck, .chanDrq, .irdaDack, .pinDmaAck, .cardDack,
    .lowChanUpperAddr, .highChanUpperAddr
  );

  irr_dma_ctrl_model irr_dma_ctrl_model_inst (
    .sys_clk, .rst, .slow, .chanDrq, .dmaAck
  );

  // clock generator
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic look;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic io_wr(input logic dp, input logic [7:0] d);
    @(posedge sys_clk);
    ioWr       <= 1'b1;
    ioDataPort <= dp;
    ioWrData   <= d;
    @(posedge sys_clk);
    ioWr <= 1'b0;
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
    io_wr(1'b0, idx);
    io_wr(1'b1, val);
  endtask

  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] v);
    io_wr(1'b0, idx);
    @(posedge sys_clk);
    ioRd       <= 1'b1;
    ioDataPort <= 1'b1;
    @(posedge sys_clk);
    ioRd <= 1'b0;
    #1 v = ioRdData;
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    logic [7:0] v;
    for (int i = 0; i < 5; i++) begin
      reg_rd(8'hD8 + 8'(i), v);
      chk(v, 8'h00, "reset value");
    end
    reg_wr(`IRR_IDX_LOW_UPPER, 8'hA5);
    reg_wr(`IRR_IDX_HIGH_UPPER, 8'hC6);
    look;
    chk(lowChanUpperAddr, 8'hA5, "low channel upper bits");
    chk(highChanUpperAddr[5:0], 6'h06, "high channel upper bits");
    reg_rd(`IRR_IDX_HIGH_UPPER, v);
    chk(v, 8'hC6, "high channel readback");
    reg_wr(`IRR_IDX_ROUTE_B, 8'hF0);
    reg_rd(`IRR_IDX_ROUTE_B, v);
    reg_wr(`IRR_IDX_ROUTE_B, (v & 8'hF0) | 8'h05);
    reg_rd(`IRR_IDX_ROUTE_B, v);
    chk(v, 8'hF5, "spare bits kept");
    reg_wr(8'h30, 8'hFF);
    reg_rd(8'h30, v);
    chk(v, 8'h00, "unmapped index");
    @(posedge sys_clk);
    ce <= 1'b0;
    reg_wr(`IRR_IDX_LOW_UPPER, 8'h3C);
    @(posedge sys_clk);
    ce <= 1'b1;
    look;
    chk(lowChanUpperAddr, 8'hA5, "frozen write");
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    look;
    chk(lowChanUpperAddr, 8'h00, "low after reset");
    chk(highChanUpperAddr, 8'h00, "high after reset");
  endtask

  task automatic cur(input logic [7:0] idx, input logic exp);
    @(posedge sys_clk);
    cursorRegWr  <= 1'b1;
    cursorRegIdx <= idx;
    @(posedge sys_clk);
    cursorRegWr <= 1'b0;
    #1 chk(irqOut[9], exp, "cursor pulse");
    look;
    chk(irqOut[9], 1'b0, "cursor pulse end");
  endtask

  task automatic t_cursor;
    reg_wr(`IRR_IDX_ROUTE_E, 8'h00);
    cur(`IRR_CURSOR_HI_IDX, 1'b0);
    reg_wr(`IRR_IDX_ROUTE_E, 8'h80);
    cur(`IRR_CURSOR_HI_IDX, 1'b1);
    cur(`IRR_CURSOR_LO_IDX, 1'b1);
    cur(8'h0D, 1'b0);
  endtask

  task automatic t_irq;
    logic hit;
    for (int k = 0; k < 4; k++) begin
      reg_wr(`IRR_IDX_ROUTE_E, {1'b0, 2'(k), 2'(k), 3'h0});
      for (int m = 0; m < 6; m++) begin
        @(posedge sys_clk);
        infraredSelect  <= (m > 1);
        highSpeedSelect <= (m > 3);
        uartIrq         <= m[0];
        irdaIrq         <= !m[0];
        parallelPortIrq <= m[0];
        look;
        hit = (m > 3) ? !m[0] : m[0];
        chk(irqOut[3], hit && k == 1, "serial line 3");
        chk(irqOut[4], hit && k == 2, "serial line 4");
        chk(irqOut[5], m[0] && k == 1, "parallel line 5");
        chk(irqOut[7], m[0] && k == 2, "parallel line 7");
        chk(irqOut & 16'hFD47, 16'h0000, "unrouted lines quiet");
      end
    end
  endtask

  task automatic dma(input logic [7:0] idx, input logic [7:0] val, input logic [4:0] src,
                     input logic [7:0] exp);
    reg_wr(idx, val);
    @(posedge sys_clk);
    {cardDrq, pinDmaRequest, irdaDrq} <= src;
    repeat (4) look;
    chk(chanDrq, exp, "channel request");
    chk({cardDack, pinDmaAck, irdaDack}, (exp != 8'h00) ? src : 5'h00, "source ack");
    @(posedge sys_clk);
    {cardDrq, pinDmaRequest, irdaDrq} <= 5'h00;
  endtask

  task automatic t_dma;
    logic [7:0] card [4] = '{8'h00, 8'h08, 8'h04, 8'h20};
    logic [7:0] ir [4]   = '{8'h00, 8'h01, 8'h02, 8'h00};
    logic [7:0] pin;
    for (int k = 0; k < 8; k++) begin
      slow <= k[0];
      pin = (k == 0) ? 8'h00 : (k < 5) ? 8'(1 << (k - 1)) : 8'(1 << k);
      dma(`IRR_IDX_ROUTE_A, 8'(k), 5'h02, pin);
      dma(`IRR_IDX_ROUTE_A, 8'(k << 3), 5'h04, pin);
    end
    for (int k = 0; k < 4; k++) begin
      dma(`IRR_IDX_ROUTE_A, 8'(k << 6), 5'h01, ir[k]);
      dma(`IRR_IDX_ROUTE_B, 8'(k), 5'h08, card[k]);
      dma(`IRR_IDX_ROUTE_B, 8'(k << 2), 5'h10, card[k]);
    end
    dma(`IRR_IDX_ROUTE_A, 8'h41, 5'h03, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst, ce, ioWr, ioRd, ioDataPort, cursorRegWr, slow} = 7'h60;
    {uartIrq, irdaIrq, infraredSelect, highSpeedSelect, parallelPortIrq} = 5'h00;
    {irdaDrq, pinDmaRequest, cardDrq} = 5'h00;
    ioWrData = 8'h00;
    cursorRegIdx = 8'h00;
    n_errors = 0;
    checks_done = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs;
    t_cursor;
    t_irq;
    t_dma;
    give_verdict;
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    give_verdict;
  end
endmodule
